// >>> rtl/tor_pkg.sv
// Shared constants, size list and types for the transform output reorder
package tor_pkg;

    // Sample and command widths
    localparam int IN_W      = 24;     // Full word growth sample width
    localparam int OUT_W     = 16;     // Width after rescaling
    localparam int SIZE_W    = 6;      // Size index field of the command
    localparam int CMD_W     = 7;      // Size index plus direction bit
    localparam int DIR_BIT   = 6;      // Position of the inverse flag
    localparam int POS_W     = 6;      // Natural order position tag
    localparam int CNT_W     = 7;      // Sample counter width
    localparam int LZ_W      = 5;      // Redundant sign bit count width
    localparam int SHIFT_W   = 6;      // Signed exponent width
    localparam int ADDR_W    = 7;      // Index into both buffer banks
    localparam int SIZE_NUM  = 4;      // Entries in the engine length list
    localparam int BUF_DEPTH = 48;     // Largest listed transform length
    localparam int BUF_WORDS = 96;     // Two banks of BUF_DEPTH

    // Reset and limit values
    localparam logic [LZ_W-1:0]    LZ_MAX     = 5'h17;
    localparam logic [SHIFT_W-1:0] DROP_BITS  = 6'h08;
    localparam logic [CNT_W-1:0]   CNT_ONE    = 7'h01;
    localparam logic [CMD_W-1:0]   CMD_RESET  = 7'h00;
    localparam logic [CNT_W-1:0]   SIZE_RESET = 7'h00;

    // Read side sequencer states
    typedef enum logic [0:0] {
        TOR_RD_IDLE = 1'b0,
        TOR_RD_RUN  = 1'b1
    } tor_rd_state_t;

    // Engine length list, addressed by zero-based size index
    function automatic logic [CNT_W-1:0] size_of(
        input logic [SIZE_W-1:0] idx
    );
        case (idx)
            6'h00:   return 7'h0C;
            6'h01:   return 7'h18;
            6'h02:   return 7'h24;
            6'h03:   return 7'h30;
            default: return 7'h30;
        endcase
    endfunction

endpackage

// >>> rtl/tor_if.sv
// Stream link between the transform engine end and the reorder end
`timescale 1ns/1ps
`default_nettype none

interface tor_if;
    import tor_pkg::*;

    // Engine to reorder: radix-reversed samples with position tags
    logic                      in_v;
    logic [CMD_W-1:0]          in_cmd;
    logic                      in_sop;
    logic [POS_W-1:0]          in_pos;
    logic [IN_W-1:0]           in_re;
    logic [IN_W-1:0]           in_im;

    // Reorder to consumer: natural order samples
    logic                      out_v;
    logic [CMD_W-1:0]          out_cmd;
    logic                      out_sop;
    logic [IN_W-1:0]           out_re;
    logic [IN_W-1:0]           out_im;
    logic signed [SHIFT_W-1:0] out_shift;

    modport engine_mp (
        output in_v, in_cmd, in_sop, in_pos, in_re, in_im,
        input  out_v, out_cmd, out_sop, out_re, out_im, out_shift
    );

    modport reorder_mp (
        input  in_v, in_cmd, in_sop, in_pos, in_re, in_im,
        output out_v, out_cmd, out_sop, out_re, out_im, out_shift
    );

endinterface

`default_nettype wire

// >>> rtl/tor_sign_count.sv
// Redundant sign bit count of one complex sample
`timescale 1ns/1ps
`default_nettype none

module tor_sign_count (
    input  wire logic [tor_pkg::IN_W-1:0] re,
    input  wire logic [tor_pkg::IN_W-1:0] im,
    output logic      [tor_pkg::LZ_W-1:0] lz
);
    import tor_pkg::*;

    // Count of top bits that merely repeat the sign
    function automatic logic [LZ_W-1:0] redundant_bits(
        input logic [IN_W-1:0] x
    );
        logic [LZ_W-1:0] n;
        logic            run;
        n   = '0;
        run = 1'b1;
        for (int i = IN_W - 2; i >= 0; i--) begin
            if (run && (x[i] == x[IN_W-1])) begin
                n = n + LZ_W'(1);
            end else begin
                run = 1'b0;
            end
        end
        return n;
    endfunction

    logic [LZ_W-1:0] lz_re;
    logic [LZ_W-1:0] lz_im;

    // Smaller of the two parts bounds the safe shift
    always_comb begin
        lz_re = redundant_bits(re);
        lz_im = redundant_bits(im);
        lz    = (lz_re < lz_im) ? lz_re : lz_im;
    end

endmodule

`default_nettype wire

// >>> rtl/tor_engine_end.sv
// Engine side end: drives tagged samples in, returns reordered output
`timescale 1ns/1ps
`default_nettype none

module tor_engine_end (
    input  wire logic                               clk,
    input  wire logic                               sys_rst,
    tor_if.engine_mp                                lnk,
    input  wire logic                               usr_valid,
    input  wire logic                               usr_first,
    input  wire logic [tor_pkg::CMD_W-1:0]          usr_cmd,
    input  wire logic [tor_pkg::POS_W-1:0]          usr_pos,
    input  wire logic [tor_pkg::IN_W-1:0]           usr_re,
    input  wire logic [tor_pkg::IN_W-1:0]           usr_im,
    output logic                                    usr_ready,
    output logic                                    usr_out_v,
    output logic                                    usr_out_sop,
    output logic      [tor_pkg::CMD_W-1:0]          usr_out_cmd,
    output logic      [tor_pkg::IN_W-1:0]           usr_out_re,
    output logic      [tor_pkg::IN_W-1:0]           usr_out_im,
    output logic signed [tor_pkg::SHIFT_W-1:0]      usr_out_shift
);
    import tor_pkg::*;

    logic ready_reg;
    logic take;

    // Stays low on the first cycle after reset so no start can land there
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= 1'b1;
        end
    end

    assign usr_ready = ready_reg;
    assign take      = usr_valid && ready_reg;

    // Valid and start flags follow accepted samples only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lnk.in_v   <= 1'b0;
            lnk.in_sop <= 1'b0;
        end else begin
            lnk.in_v   <= take;
            lnk.in_sop <= take && usr_first;
        end
    end

    // Command, position and data pass straight through registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lnk.in_cmd <= CMD_RESET;
            lnk.in_pos <= '0;
            lnk.in_re  <= '0;
            lnk.in_im  <= '0;
        end else if (take) begin
            lnk.in_cmd <= usr_cmd;
            lnk.in_pos <= usr_pos;
            lnk.in_re  <= usr_re;
            lnk.in_im  <= usr_im;
        end
    end

    // Consumer side copy of the reordered stream
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            usr_out_v     <= 1'b0;
            usr_out_sop   <= 1'b0;
            usr_out_cmd   <= CMD_RESET;
            usr_out_re    <= '0;
            usr_out_im    <= '0;
            usr_out_shift <= '0;
        end else begin
            usr_out_v     <= lnk.out_v;
            usr_out_sop   <= lnk.out_sop;
            usr_out_cmd   <= lnk.out_cmd;
            usr_out_re    <= lnk.out_re;
            usr_out_im    <= lnk.out_im;
            usr_out_shift <= lnk.out_shift;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/tor_reorder_end.sv
// Reorder end: ping-pong buffer that emits each transform in natural order
// Functional notes
// - Source holds valid high only on samples
// - Forward only: 6-bit size index command
// - Dynamic mode: 7-bit, top bit means inverse
// - Size field indexes the length list
// - Start pulse only on first valid sample
// - One idle cycle after reset before start
// - Store each sample at its position tag
// - Physically reorder samples into natural order
// - Output valid only on real output samples
// - Output size command travels with data
// - Output start only on first emitted sample
// - Plain variant passes samples unchanged
// - Both ends share one length list
// - Inputs come straight from engine outputs
// - Rescale variant: one exponent per transform
// - Find least redundant sign bits per transform
// - Drop that many top bits from all
// - Then drop low bits to output width
// - Exponent constant within, free between transforms
// - Keep input fraction bits, output width total
`timescale 1ns/1ps
`default_nettype none

module tor_reorder_end #(
    parameter bit RESCALE_EN = 1'b0,   // Block floating point output
    parameter bit DYN_EN     = 1'b0    // Forward and inverse command
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    tor_if.reorder_mp lnk
);
    import tor_pkg::*;

    // Address in one of the two banks
    function automatic logic [ADDR_W-1:0] buf_addr(
        input logic            bank,
        input logic [POS_W-1:0] p
    );
        return bank ? (ADDR_W'(p) + ADDR_W'(BUF_DEPTH)) : ADDR_W'(p);
    endfunction

    // Sample storage, real part above imaginary
    logic [2*IN_W-1:0] mem [0:BUF_WORDS-1];

    // Write side state
    logic                 wr_active_reg;
    logic                 wr_bank_reg;
    logic [CNT_W-1:0]     wr_cnt_reg;
    logic [CNT_W-1:0]     wr_size_reg;
    logic [CMD_W-1:0]     wr_cmd_reg;
    logic [LZ_W-1:0]      wr_lz_reg;

    // Per bank record of a completed transform
    logic [1:0]           full_reg;
    logic [CMD_W-1:0]     bcmd_reg  [0:1];
    logic [CNT_W-1:0]     bsize_reg [0:1];
    logic [LZ_W-1:0]      blz_reg   [0:1];

    // Read side state
    tor_rd_state_t        rd_state_reg;
    tor_rd_state_t        rd_state_next;
    logic                 rd_bank_reg;
    logic [CNT_W-1:0]     rd_idx_reg;

    // Combinational helpers
    logic                 wr_take;
    logic                 wr_last;
    logic [CMD_W-1:0]     cmd_in;
    logic [CMD_W-1:0]     cmd_now;
    logic [CNT_W-1:0]     size_now;
    logic [CNT_W-1:0]     cnt_now;
    logic [LZ_W-1:0]      samp_lz;
    logic [LZ_W-1:0]      lz_now;
    logic                 rd_go;
    logic                 rd_done;
    logic [2*IN_W-1:0]    rd_word;
    logic [IN_W-1:0]      rd_re;
    logic [IN_W-1:0]      rd_im;
    logic [IN_W-1:0]      sh_re;
    logic [IN_W-1:0]      sh_im;
    logic [LZ_W-1:0]      rd_lz;

    // Redundant sign bits of the incoming sample
    tor_sign_count tor_sign_count_inst (
        .re (lnk.in_re),
        .im (lnk.in_im),
        .lz (samp_lz)
    );

    // Command decode; inverse flag kept only in dynamic mode
    always_comb begin
        cmd_in = lnk.in_cmd;
        if (!DYN_EN) begin
            cmd_in[DIR_BIT] = 1'b0;
        end
        // Start sample takes command, everything else uses the held one
        cmd_now  = lnk.in_sop ? cmd_in : wr_cmd_reg;
        size_now = lnk.in_sop ? size_of(cmd_in[SIZE_W-1:0])
                              : wr_size_reg;
        cnt_now  = lnk.in_sop ? CNT_ONE : (wr_cnt_reg + CNT_ONE);
        if (lnk.in_sop || (samp_lz < wr_lz_reg)) begin
            lz_now = samp_lz;
        end else begin
            lz_now = wr_lz_reg;
        end
    end

    // A sample counts on valid once a transform has started
    assign wr_take = lnk.in_v && (lnk.in_sop || wr_active_reg);
    assign wr_last = wr_take && (cnt_now == size_now);

    // Write side progress through one transform
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_active_reg <= 1'b0;
            wr_bank_reg   <= 1'b0;
            wr_cnt_reg    <= '0;
            wr_size_reg   <= SIZE_RESET;
            wr_cmd_reg    <= CMD_RESET;
            wr_lz_reg     <= LZ_MAX;
        end else if (wr_take) begin
            wr_cnt_reg  <= cnt_now;
            wr_size_reg <= size_now;
            wr_cmd_reg  <= cmd_now;
            wr_lz_reg   <= lz_now;
            if (wr_last) begin
                wr_active_reg <= 1'b0;
                wr_bank_reg   <= ~wr_bank_reg;
            end else begin
                wr_active_reg <= 1'b1;
            end
        end
    end

    // Each sample lands at its natural order position
    always_ff @(posedge clk) begin
        if (wr_take) begin
            mem[buf_addr(wr_bank_reg, lnk.in_pos)] <=
                {lnk.in_re, lnk.in_im};
        end
    end

    // Bank record written when the last sample arrives
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int b = 0; b < 2; b++) begin
                bcmd_reg[b]  <= CMD_RESET;
                bsize_reg[b] <= SIZE_RESET;
                blz_reg[b]   <= LZ_MAX;
            end
        end else if (wr_last) begin
            bcmd_reg[wr_bank_reg]  <= cmd_now;
            bsize_reg[wr_bank_reg] <= size_now;
            blz_reg[wr_bank_reg]   <= lz_now;
        end
    end

    // Bank full flags; a fill wins over a same-cycle release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            full_reg <= 2'b00;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (wr_last && (wr_bank_reg == 1'(b))) begin
                    full_reg[b] <= 1'b1;
                end else if (rd_done && (rd_bank_reg == 1'(b))) begin
                    full_reg[b] <= 1'b0;
                end
            end
        end
    end

    // Reading starts only on a completely buffered bank
    assign rd_go   = full_reg[rd_bank_reg];
    assign rd_done = (rd_state_reg == TOR_RD_RUN) &&
                     (rd_idx_reg == (bsize_reg[rd_bank_reg] - CNT_ONE));

    // Read sequencer
    always_comb begin
        case (rd_state_reg)
            TOR_RD_IDLE: rd_state_next = rd_go ? TOR_RD_RUN : TOR_RD_IDLE;
            TOR_RD_RUN:  rd_state_next = rd_done ? TOR_RD_IDLE : TOR_RD_RUN;
            default:     rd_state_next = TOR_RD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_state_reg <= TOR_RD_IDLE;
            rd_bank_reg  <= 1'b0;
            rd_idx_reg   <= '0;
        end else begin
            rd_state_reg <= rd_state_next;
            if (rd_done) begin
                rd_bank_reg <= ~rd_bank_reg;
                rd_idx_reg  <= '0;
            end else if (rd_state_reg == TOR_RD_RUN) begin
                rd_idx_reg <= rd_idx_reg + CNT_ONE;
            end
        end
    end

    // Natural order fetch and block floating point alignment
    always_comb begin
        rd_word = mem[buf_addr(rd_bank_reg, rd_idx_reg[POS_W-1:0])];
        rd_re   = rd_word[2*IN_W-1:IN_W];
        rd_im   = rd_word[IN_W-1:0];
        rd_lz   = blz_reg[rd_bank_reg];
        sh_re   = rd_re << rd_lz;
        sh_im   = rd_im << rd_lz;
    end

    // Output stream registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lnk.out_v   <= 1'b0;
            lnk.out_sop <= 1'b0;
        end else begin
            lnk.out_v   <= (rd_state_reg == TOR_RD_RUN);
            lnk.out_sop <= (rd_state_reg == TOR_RD_RUN) &&
                           (rd_idx_reg == '0);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lnk.out_cmd   <= CMD_RESET;
            lnk.out_re    <= '0;
            lnk.out_im    <= '0;
            lnk.out_shift <= '0;
        end else if (rd_state_reg == TOR_RD_RUN) begin
            lnk.out_cmd <= bcmd_reg[rd_bank_reg];
            if (RESCALE_EN) begin
                // Top OUT_W bits after alignment, sign extended
                lnk.out_re <= IN_W'($signed(sh_re[IN_W-1 -: OUT_W]));
                lnk.out_im <= IN_W'($signed(sh_im[IN_W-1 -: OUT_W]));
                lnk.out_shift <= DROP_BITS - SHIFT_W'(rd_lz);
            end else begin
                lnk.out_re    <= rd_re;
                lnk.out_im    <= rd_im;
                lnk.out_shift <= '0;
            end
        end
    end

endmodule

`default_nettype wire

// >>> testbench/tor_link_chk.sv
// Checks on the link between the engine end and the plain reorder end
`timescale 1ns/1ps
`default_nettype none

module tor_link_chk (
    input wire logic                               clk,
    input wire logic                               sys_rst,
    input wire logic                               in_v,
    input wire logic                               in_sop,
    input wire logic [tor_pkg::CMD_W-1:0]          in_cmd,
    input wire logic                               out_v,
    input wire logic                               out_sop,
    input wire logic [tor_pkg::CMD_W-1:0]          out_cmd,
    input wire logic signed [tor_pkg::SHIFT_W-1:0] out_shift
);
    import tor_pkg::*;

    logic [CNT_W-1:0] run_left_reg;  // Outputs still owed in this run
    logic [CNT_W-1:0] in_left_reg;   // Inputs still owed in this transform

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Transform length per size index
    function automatic logic [CNT_W-1:0] len_of(input logic [SIZE_W-1:0] i);
        case (i)
            6'h00:   return 7'h0C;
            6'h01:   return 7'h18;
            6'h02:   return 7'h24;
            default: return 7'h30;
        endcase
    endfunction

    // Count down the output run opened by each start pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_left_reg <= 7'h00;
        end else if (out_sop) begin
            run_left_reg <= len_of(out_cmd[SIZE_W-1:0]) - CNT_ONE;
        end else if (out_v && run_left_reg != 7'h00) begin
            run_left_reg <= run_left_reg - CNT_ONE;
        end
    end

    // Count down the inputs of the transform being filled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_left_reg <= 7'h00;
        end else if (in_v && in_sop) begin
            in_left_reg <= len_of(in_cmd[SIZE_W-1:0]) - CNT_ONE;
        end else if (in_v && in_left_reg != 7'h00) begin
            in_left_reg <= in_left_reg - CNT_ONE;
        end
    end

    AST_SOP_VALID: assert property (
        out_sop |-> out_v
    ) else $error("Output start without valid");
    AST_SOP_FIRST: assert property (
        out_sop |-> run_left_reg == 7'h00
    ) else $error("Output start inside a run");
    AST_RUN_START: assert property (
        out_v && run_left_reg == 7'h00 |-> out_sop
    ) else $error("Output run opened without start");
    AST_RUN_FULL: assert property (
        run_left_reg != 7'h00 |-> out_v
    ) else $error("Output run broken before its length");
    AST_CMD_HOLD: assert property (
        out_v && !out_sop |-> $stable(out_cmd) && $stable(out_shift)
    ) else $error("Command or exponent changed inside a run");
    AST_CMD_FWD: assert property (
        out_v |-> !out_cmd[DIR_BIT]
    ) else $error("Inverse flag set in forward only mode");
    AST_SHIFT_ZERO: assert property (
        out_v |-> out_shift == 6'sh00
    ) else $error("Plain end gave a nonzero exponent");
    // Last sample edge, bank full, reader runs, then the output register
    AST_LAST_OUT: assert property (
        in_v && !in_sop && in_left_reg == CNT_ONE |-> ##3 out_v
    ) else $error("Output not started three cycles after last input");
    AST_RST_QUIET: assert property (
        disable iff (1'b0) sys_rst |=> !out_v && !out_sop
    ) else $error("Output active during reset");

endmodule

`default_nettype wire

// >>> testbench/transform_output_reorder_tb.sv
// Bench: one stimulus feeds a plain and a rescaling reorder pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module transform_output_reorder_tb;
    import tor_pkg::*;

    typedef struct packed {
        logic [IN_W-1:0]    re;
        logic [IN_W-1:0]    im;
        logic               sop;
        logic [CMD_W-1:0]   cmd;
        logic [SHIFT_W-1:0] sh;
    } tor_exp_t;

    logic             clk = 1'b0;
    logic             sys_rst;
    logic             u_v;
    logic             u_first;
    logic [CMD_W-1:0] u_cmd;
    logic [POS_W-1:0] u_pos;
    logic [IN_W-1:0]  u_re;
    logic [IN_W-1:0]  u_im;
    wire logic        rdy_a;
    wire logic        rdy_b;
    wire logic        oa_v;
    wire logic        ob_v;
    wire tor_exp_t    oa;
    wire tor_exp_t    ob;
    tor_exp_t         qa[$];
    tor_exp_t         qb[$];
    int               n_fail = 0;
    int               cmp_count = 0;

    tor_if lnk_a ();
    tor_if lnk_b ();

    // Plain pair, watched by the checker
    tor_engine_end tor_engine_end_inst (
        .clk(clk), .sys_rst(sys_rst), .lnk(lnk_a.engine_mp),
        .usr_valid(u_v), .usr_first(u_first), .usr_cmd(u_cmd),
        .usr_pos(u_pos), .usr_re(u_re), .usr_im(u_im), .usr_ready(rdy_a),
        .usr_out_v(oa_v), .usr_out_sop(oa.sop), .usr_out_cmd(oa.cmd),
        .usr_out_re(oa.re), .usr_out_im(oa.im), .usr_out_shift(oa.sh)
    );
    tor_reorder_end tor_reorder_end_inst (
        .clk(clk), .sys_rst(sys_rst), .lnk(lnk_a.reorder_mp)
    );
    // Rescaling pair with forward and inverse commands
    tor_engine_end tor_engine_end_inst_b (
        .clk(clk), .sys_rst(sys_rst), .lnk(lnk_b.engine_mp),
        .usr_valid(u_v), .usr_first(u_first), .usr_cmd(u_cmd),
        .usr_pos(u_pos), .usr_re(u_re), .usr_im(u_im), .usr_ready(rdy_b),
        .usr_out_v(ob_v), .usr_out_sop(ob.sop), .usr_out_cmd(ob.cmd),
        .usr_out_re(ob.re), .usr_out_im(ob.im), .usr_out_shift(ob.sh)
    );
    tor_reorder_end #(.RESCALE_EN(1'b1), .DYN_EN(1'b1))
        tor_reorder_end_inst_b (
        .clk(clk), .sys_rst(sys_rst), .lnk(lnk_b.reorder_mp)
    );
    tor_link_chk tor_link_chk_inst (
        .clk(clk), .sys_rst(sys_rst), .in_v(lnk_a.in_v),
        .in_sop(lnk_a.in_sop), .in_cmd(lnk_a.in_cmd), .out_v(lnk_a.out_v),
        .out_sop(lnk_a.out_sop), .out_cmd(lnk_a.out_cmd),
        .out_shift(lnk_a.out_shift)
    );

    // Clock of 8 ns period
    always #4 clk = ~clk;

    function automatic int len_of(input int idx);
        return (idx == 0) ? 12 : (idx == 1) ? 24 : (idx == 2) ? 36 : 48;
    endfunction

    // Redundant sign bits of one word
    function automatic int rsb(input logic [IN_W-1:0] x);
        int n;
        n = 0;
        for (int i = IN_W - 2; i >= 0 && x[i] == x[IN_W-1]; i--) n++;
        return n;
    endfunction

    // Drop lz top bits, keep the top output bits, sign extend
    function automatic logic [IN_W-1:0] scale(input logic [IN_W-1:0] x,
                                              input int lz);
        logic [IN_W-1:0] t;
        t = x << lz;
        return {{(IN_W-OUT_W){t[IN_W-1]}}, t[IN_W-1 -: OUT_W]};
    endfunction

    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One sample offered at the falling edge, taken at the next rise
    task automatic put(input logic f, input logic [CMD_W-1:0] c,
                       input int p, input logic [IN_W-1:0] r, i);
        @(negedge clk);
        u_v = 1'b1;
        u_first = f;
        u_cmd = c;
        u_pos = POS_W'(p);
        u_re = r;
        u_im = i;
        `CHK({rdy_a, rdy_b}, 2'b11)
    endtask

    task automatic idle();
        @(negedge clk);
        u_v = 1'b0;
        u_first = 1'b0;
    endtask

    // Send one transform in scrambled order; cut stops it early
    task automatic xf(input int idx, input logic dir, input int k,
                      input int cut, input logic gap);
        logic [IN_W-1:0] ar[48];
        logic [IN_W-1:0] ai[48];
        tor_exp_t        e;
        int              n;
        int              lz;
        int              p;
        n = len_of(idx);
        lz = IN_W - 1;
        for (int j = 0; j < n; j++) begin
            ar[j] = IN_W'(j + 1) << k;
            ai[j] = -ar[j];
            if (rsb(ar[j]) < lz) lz = rsb(ar[j]);
            if (rsb(ai[j]) < lz) lz = rsb(ai[j]);
        end
        // Stride 5 is coprime to every listed length
        for (int j = 0; j < (cut > 0 ? cut : n); j++) begin
            p = (j * 5 + 3) % n;
            put(j == 0, {dir, idx[5:0]}, p, ar[p], ai[p]);
            if (gap && j % 7 == 3) idle();
        end
        if (cut > 0) return;
        for (int j = 0; j < n; j++) begin
            e = {ar[j], ai[j], j == 0, 1'b0, idx[5:0], 6'h00};
            qa.push_back(e);
            e = {scale(ar[j], lz), scale(ai[j], lz), j == 0, dir,
                 idx[5:0], SHIFT_W'(IN_W - OUT_W - lz)};
            qb.push_back(e);
        end
    endtask

    task automatic pop_chk(ref tor_exp_t q[$], input tor_exp_t g);
        tor_exp_t e;
        e = q.size() > 0 ? q.pop_front() : ~g;
        `CHK(g, e)
    endtask

    // Compare each emitted sample with the oldest expected one
    always @(negedge clk) begin
        if (oa_v) pop_chk(qa, oa);
        if (ob_v) pop_chk(qb, ob);
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        u_v = 1'b0;
        u_first = 1'b0;
        u_cmd = 7'h00;
        u_pos = 6'h00;
        u_re = 24'h000000;
        u_im = 24'h000000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        `CHK({rdy_a, rdy_b}, 2'b00)
        repeat (2) @(negedge clk);
        // Samples without a start must be dropped
        for (int j = 0; j < 3; j++) put(1'b0, 7'h01, j, 24'h00ABCD, 24'h0);
        xf(0, 1'b0, 2, 5, 1'b0);   // Aborted by the next start
        xf(0, 1'b1, 3, 0, 1'b0);
        xf(1, 1'b0, 6, 0, 1'b0);
        xf(2, 1'b1, 9, 0, 1'b0);
        xf(3, 1'b0, 12, 0, 1'b0);
        idle();
        xf(5, 1'b1, 17, 0, 1'b1);  // Unlisted index, gaps in valid
        idle();
        for (int j = 0; j < 300 && qa.size() + qb.size() > 0; j++)
            @(negedge clk);
        `CHK(qa.size() + qb.size(), 0)
        finish_test();
    end

    // Watchdog well past the expected run of some 250 cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        finish_test();
    end

endmodule

`default_nettype wire
